// ### pkg/stsp_pkg.sv
package stsp_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned DW = 18;
   localparam int unsigned CHAIN_W = 48;
   localparam int unsigned IR_W = 8;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned SYNC_W = 43;

   // ------------------------------------------------------------
   // instruction and selector codes
   // ------------------------------------------------------------
   localparam logic [7:0] IR_CAPTURE = 8'h81;
   localparam logic [7:0] OP_BYPASS = 8'hff;
   localparam logic [7:0] OP_SAMPLE = 8'h82;
   localparam logic [7:0] OP_RUN_TEST_INSTRUCTION = 8'h0a;
   localparam logic [7:0] OP_SELSCAN = 8'h0e;
   localparam logic [2:0] SEL_CMP_RND = 3'h3;
   localparam logic [2:0] SEL_CMP_CNT = 3'h7;
   localparam logic [2:0] SEL_RESET = 3'h0;

   // ------------------------------------------------------------
   // chain layout and feedback taps
   // ------------------------------------------------------------
   localparam int unsigned A_LO = 0;
   localparam int unsigned B_LO = 18;
   localparam int unsigned CTRL_LO = 36;
   localparam int unsigned OE1AB = 44;
   localparam int unsigned OE2AB = 45;
   localparam int unsigned OE1BA = 46;
   localparam int unsigned OE2BA = 47;
   localparam int unsigned TAP_HI = 17;
   localparam int unsigned TAP_MID = 10;
   localparam int unsigned HALF = 9;
   localparam logic [17:0] CNT_STEP = 18'h00001;

   typedef enum logic [3:0] {
      TLR = 4'h0, RTI = 4'h1, SELDR = 4'h3, CAPDR = 4'h2,
      SHDR = 4'h6, EX1DR = 4'h7, PSDR = 4'h5, EX2DR = 4'h4,
      UPDR = 4'hc, SELIR = 4'hd, CAPIR = 4'hf, SHIR = 4'he,
      EX1IR = 4'ha, PSIR = 4'hb, EX2IR = 4'h9, UPIR = 4'h8
   } stsp_tap_e;

   // en_n[0]=byte1 a->b, [1]=byte2 a->b, [2]=byte1 b->a, [3]=byte2 b->a
   typedef struct packed {
      logic [3:0] en_n;
      logic [17:0] b;
      logic [17:0] a;
   } stsp_pins_s;

   typedef struct packed {
      logic [17:0] sig;
      logic [17:0] pat;
   } stsp_obs_s;
endpackage

// ### hw/stsp_sync.sv
// two-stage synchroniser for every pin that enters from outside
module stsp_sync #(
   parameter int unsigned W = 1
) (
   // clock
   input wire logic clk,
   // pins
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk)
   begin
      meta <= d;
      q <= meta;
   end
endmodule // stsp_sync

// ### hw/stsp_fifo.sv
// small fifo; read data leave from a register
module stsp_fifo #(
   parameter int unsigned W = 36,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fill side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;

   wire push = in_valid && in_ready;
   wire pop = (count != '0) && (!out_valid || out_ready);
   wire full = count == (AW+1)'(DEPTH);

   assign in_ready = !full;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
      if (pop)
      begin
         out_data <= mem[rd_ptr];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
         if (pop)
         begin
            out_valid <= 1'b1;
         end
         else if (out_ready)
         begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // stsp_fifo

// ### hw/stsp_tap_core.sv
module stsp_tap_core (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // test access port
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // transceiver pins
   input wire logic [17:0] a_in,
   input wire logic [17:0] b_in,
   input wire logic byte1_a_to_b_enable_n,
   input wire logic byte2_a_to_b_enable_n,
   input wire logic byte1_b_to_a_enable_n,
   input wire logic byte2_b_to_a_enable_n,
   output logic [17:0] a_out,
   output logic [17:0] a_oe,
   output logic [17:0] b_out,
   output logic [17:0] b_oe,
   // observation stream
   output stsp_pkg::stsp_obs_s obs_data,
   output logic obs_valid,
   input wire logic obs_ready,
   output logic obs_overflow
);
   // ------------------------------------------------------------
   // pin synchronisers and tck edges
   // ------------------------------------------------------------
   stsp_pkg::stsp_pins_s pins;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic tck_d;

   stsp_sync #(.W(stsp_pkg::SYNC_W)) u_sync (
      .clk(clk),
      .d({tck, tms, tdi, byte2_b_to_a_enable_n, byte1_b_to_a_enable_n,
          byte2_a_to_b_enable_n, byte1_a_to_b_enable_n, b_in, a_in}),
      .q({tck_s, tms_s, tdi_s, pins})
   );

   always_ff @(posedge clk)
   begin
      tck_d <= reset ? 1'b0 : tck_s;
   end

   wire rise = tck_s && !tck_d;
   wire fall = !tck_s && tck_d;

   // ------------------------------------------------------------
   // tap controller
   // ------------------------------------------------------------
   stsp_pkg::stsp_tap_e state;
   stsp_pkg::stsp_tap_e next_state;

   always_comb
   begin
      case (state)
         stsp_pkg::TLR: next_state = tms_s ? stsp_pkg::TLR : stsp_pkg::RTI;
         stsp_pkg::RTI: next_state = tms_s ? stsp_pkg::SELDR : stsp_pkg::RTI;
         stsp_pkg::SELDR:
            next_state = tms_s ? stsp_pkg::SELIR : stsp_pkg::CAPDR;
         stsp_pkg::CAPDR:
            next_state = tms_s ? stsp_pkg::EX1DR : stsp_pkg::SHDR;
         stsp_pkg::SHDR:
            next_state = tms_s ? stsp_pkg::EX1DR : stsp_pkg::SHDR;
         stsp_pkg::EX1DR:
            next_state = tms_s ? stsp_pkg::UPDR : stsp_pkg::PSDR;
         stsp_pkg::PSDR:
            next_state = tms_s ? stsp_pkg::EX2DR : stsp_pkg::PSDR;
         stsp_pkg::EX2DR:
            next_state = tms_s ? stsp_pkg::UPDR : stsp_pkg::SHDR;
         stsp_pkg::UPDR:
            next_state = tms_s ? stsp_pkg::SELDR : stsp_pkg::RTI;
         stsp_pkg::SELIR:
            next_state = tms_s ? stsp_pkg::TLR : stsp_pkg::CAPIR;
         stsp_pkg::CAPIR:
            next_state = tms_s ? stsp_pkg::EX1IR : stsp_pkg::SHIR;
         stsp_pkg::SHIR:
            next_state = tms_s ? stsp_pkg::EX1IR : stsp_pkg::SHIR;
         stsp_pkg::EX1IR:
            next_state = tms_s ? stsp_pkg::UPIR : stsp_pkg::PSIR;
         stsp_pkg::PSIR:
            next_state = tms_s ? stsp_pkg::EX2IR : stsp_pkg::PSIR;
         stsp_pkg::EX2IR:
            next_state = tms_s ? stsp_pkg::UPIR : stsp_pkg::SHIR;
         stsp_pkg::UPIR:
            next_state = tms_s ? stsp_pkg::SELDR : stsp_pkg::RTI;
         default: next_state = stsp_pkg::TLR;
      endcase
   end

   // the controller changes tms at fall; we only act on it at rise
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= stsp_pkg::TLR;
      end
      else if (rise)
      begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic [7:0] ir;
   logic [7:0] ir_shift;
   logic [2:0] sel;
   logic [2:0] sel_shift;
   logic bypass_bit;
   logic [47:0] chain;
   logic [47:0] shadow;

   wire [3:0] en_n = pins.en_n;
   wire a2b = !en_n[0];
   wire dir_ok = (en_n[0] != en_n[2]) && (en_n[1] != en_n[3])
      && (en_n[0] == en_n[1]);
   wire ir_run_test_instruction = (ir == stsp_pkg::OP_RUN_TEST_INSTRUCTION) && dir_ok;
   wire sel_chain = ir == stsp_pkg::OP_SAMPLE;
   wire sel_sel = ir == stsp_pkg::OP_SELSCAN;
   wire sel_byp = !sel_chain && !sel_sel;
   wire op_rnd = sel == stsp_pkg::SEL_CMP_RND;
   wire op_cnt = sel == stsp_pkg::SEL_CMP_CNT;
   wire run_active = ir_run_test_instruction && (state == stsp_pkg::RTI)
      && (op_rnd || op_cnt);

   wire cap_ir = state == stsp_pkg::CAPIR;
   wire sh_ir = state == stsp_pkg::SHIR;
   wire cap_dr = state == stsp_pkg::CAPDR;
   wire sh_dr = state == stsp_pkg::SHDR;

   // ------------------------------------------------------------
   // run-test arithmetic
   // ------------------------------------------------------------
   // only data cells take part; control cells 47..36 ride along
   wire [17:0] a_cells = chain[stsp_pkg::A_LO +: stsp_pkg::DW];
   wire [17:0] b_cells = chain[stsp_pkg::B_LO +: stsp_pkg::DW];
   wire [17:0] in_cells = a2b ? a_cells : b_cells;
   wire [17:0] out_cells = a2b ? b_cells : a_cells;
   wire [17:0] in_pins = a2b ? pins.a : pins.b;
   wire in_fb = in_cells[stsp_pkg::TAP_HI] ^ in_cells[stsp_pkg::TAP_MID];
   wire out_fb = out_cells[stsp_pkg::TAP_HI]
      ^ out_cells[stsp_pkg::TAP_MID];
   wire [17:0] sig_next = {in_cells[16:0], in_fb} ^ in_pins;
   wire [17:0] rnd_next = {out_cells[16:0], out_fb};
   wire [17:0] cnt_next = out_cells + stsp_pkg::CNT_STEP;
   wire [17:0] out_next = op_cnt ? cnt_next : rnd_next;
   wire [11:0] ctrl_cells = chain[47:stsp_pkg::CTRL_LO];
   wire [47:0] run_chain = a2b ? {ctrl_cells, out_next, sig_next}
      : {ctrl_cells, sig_next, out_next};
   wire [47:0] cap_chain = {en_n, chain[43:stsp_pkg::CTRL_LO],
      pins.b, pins.a};

   // ------------------------------------------------------------
   // rising-edge registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ir_shift <= stsp_pkg::IR_CAPTURE;
      end
      else if (rise && cap_ir)
      begin
         ir_shift <= stsp_pkg::IR_CAPTURE;
      end
      else if (rise && sh_ir)
      begin
         ir_shift <= {tdi_s, ir_shift[7:1]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         bypass_bit <= 1'b0;
         sel_shift <= stsp_pkg::SEL_RESET;
      end
      else if (rise && cap_dr)
      begin
         bypass_bit <= 1'b0;
      end
      else if (rise && sh_dr)
      begin
         bypass_bit <= tdi_s;
         sel_shift <= sel_sel ? {tdi_s, sel_shift[2:1]} : sel_shift;
      end
   end

   // seeding the chain is the controller's job before run-test
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         chain <= '0;
      end
      else if (rise && cap_dr && sel_chain)
      begin
         chain <= cap_chain;
      end
      else if (rise && sh_dr && sel_chain)
      begin
         chain <= {tdi_s, chain[47:1]};
      end
      else if (rise && run_active)
      begin
         chain <= run_chain;
      end
   end

   // ------------------------------------------------------------
   // falling-edge registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ir <= stsp_pkg::OP_BYPASS;
         sel <= stsp_pkg::SEL_RESET;
      end
      else if (fall && state == stsp_pkg::TLR)
      begin
         ir <= stsp_pkg::OP_BYPASS;
      end
      else if (fall && state == stsp_pkg::UPIR)
      begin
         ir <= ir_shift;
      end
      else if (fall && state == stsp_pkg::UPDR && sel_sel)
      begin
         sel <= sel_shift;
      end
   end

   wire dr_out = sel_byp ? bypass_bit
      : (sel_chain ? chain[0] : sel_shift[0]);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (fall)
      begin
         tdo_oe <= sh_ir || sh_dr;
         tdo <= sh_ir ? ir_shift[0] : dr_out;
      end
   end

   wire upd_shadow = (state == stsp_pkg::UPDR && sel_chain) || run_active;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         shadow <= '0;
      end
      else if (fall && upd_shadow)
      begin
         shadow <= chain;
      end
   end

   // pins take the latch value of this very fall, not the one before
   wire [47:0] next_shadow = upd_shadow ? chain : shadow;

   // enables are active low; byte1 is bits 8..0, byte2 bits 17..9
   wire [17:0] b_drive = {{stsp_pkg::HALF{!next_shadow[stsp_pkg::OE2AB]}},
      {stsp_pkg::HALF{!next_shadow[stsp_pkg::OE1AB]}}};
   wire [17:0] a_drive = {{stsp_pkg::HALF{!next_shadow[stsp_pkg::OE2BA]}},
      {stsp_pkg::HALF{!next_shadow[stsp_pkg::OE1BA]}}};

   // the transceiver path itself lies outside; pins float in normal mode
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         a_out <= '0;
         b_out <= '0;
         a_oe <= '0;
         b_oe <= '0;
      end
      else if (fall)
      begin
         a_out <= next_shadow[stsp_pkg::A_LO +: stsp_pkg::DW];
         b_out <= next_shadow[stsp_pkg::B_LO +: stsp_pkg::DW];
         a_oe <= ir_run_test_instruction ? a_drive : '0;
         b_oe <= ir_run_test_instruction ? b_drive : '0;
      end
   end

   // ------------------------------------------------------------
   // observation fifo
   // ------------------------------------------------------------
   logic fifo_ready;
   stsp_pkg::stsp_obs_s obs_word;

   assign obs_word = '{sig: sig_next, pat: out_next};
   wire obs_push = rise && run_active;

   stsp_fifo #(.W(2 * stsp_pkg::DW), .DEPTH(stsp_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_data(obs_word),
      .in_valid(obs_push),
      .in_ready(fifo_ready),
      .out_data(obs_data),
      .out_valid(obs_valid),
      .out_ready(obs_ready)
   );

   // tck cannot be stalled, so a full fifo drops words; the set wins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         obs_overflow <= 1'b0;
      end
      else if (obs_push && !fifo_ready)
      begin
         obs_overflow <= 1'b1;
      end
      else if (state == stsp_pkg::TLR)
      begin
         obs_overflow <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   AST_IR_CAPTURE: assert property (
      rise && cap_ir |=> ir_shift == stsp_pkg::IR_CAPTURE)
      else $error("capture-ir did not load 10000001");
   AST_IR_SHIFT: assert property (rise && sh_ir |=>
      ir_shift[7] == $past(tdi_s))
      else $error("shift-ir did not take tdi");
   AST_TDO_FALL: assert property (!fall |=>
      $stable(tdo) && $stable(tdo_oe))
      else $error("tdo changed outside a falling edge");
   AST_PIN_FALL: assert property (!fall |=>
      $stable(a_out) && $stable(b_out) && $stable(a_oe) && $stable(b_oe))
      else $error("pins changed outside a falling edge");
   AST_TDO_ON: assert property (fall && sh_ir |=> tdo_oe)
      else $error("tdo not driven in shift");
   AST_TDO_OFF: assert property (
      fall && state == stsp_pkg::EX1IR |=> !tdo_oe)
      else $error("tdo not released in exit1-ir");
   AST_IR_UPDATE: assert property (
      fall && state == stsp_pkg::UPIR |=> ir == $past(ir_shift))
      else $error("update-ir did not load instruction");
   AST_BYPASS_ZERO: assert property (
      rise && cap_dr |=> !bypass_bit)
      else $error("bypass bit did not capture zero");
   AST_COUNT_UP: assert property (
      rise && run_active && op_cnt && $stable(a2b)
      |=> out_cells == $past(out_cells) + 18'h00001)
      else $error("count did not step by one");
   AST_ZERO_SEED: assert property (
      rise && run_active && op_rnd && out_cells == '0 && $stable(a2b)
      |=> out_cells == '0)
      else $error("zero seed left zero");
   AST_CTRL_HOLD: assert property (
      rise && run_active |=> ctrl_cells == $past(ctrl_cells))
      else $error("control cells changed in run-test");
   AST_SHADOW_RUN: assert property (
      fall && run_active |=> shadow == $past(chain)
      && {b_out, a_out} == $past(chain[35:0]))
      else $error("pattern not latched and driven at fall");
endmodule // stsp_tap_core

// ### verification/stsp_tap_ctrl.sv
// ------------------------------------------------------------
// test controller on the far side of the access port
// ------------------------------------------------------------
module stsp_tap_ctrl (
   // test access port
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // tck rests low between calls, so the device sees no stray edges
   task automatic cyc(input logic m, input logic d, output logic o,
      output logic oe);
      tms = m;
      tdi = d;
      #62.5 tck = 1'b1;
      o = tdo;
      oe = tdo_oe;
      #62.5 tck = 1'b0;
   endtask
   task automatic idle(input logic m, input int n);
      logic b;
      logic e;
      repeat (n) cyc(m, 1'b0, b, e);
   endtask
   // one scan that starts and ends in run-test/idle
   task automatic scan(input logic ir, input logic [47:0] v, input int n,
      output logic [47:0] o, output logic [47:0] oe, output logic ex);
      logic b;
      o = '0;
      oe = '0;
      cyc(1'b1, 1'b0, b, ex);
      if (ir)
         cyc(1'b1, 1'b0, b, ex);
      idle(1'b0, 2);
      for (int i = 0; i < n; i++)
         cyc(i == n - 1, v[i], o[i], oe[i]);
      cyc(1'b1, 1'b0, b, ex);
      idle(1'b0, 1);
   endtask
endmodule // stsp_tap_ctrl

// ### verification/test_scan_tap_signature_pattern_test.sv
module test_scan_tap_signature_pattern_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk, reset, tck, tms, tdi, tdo, tdo_oe, obs_valid, obs_ready;
   logic obs_overflow, x;
   logic byte1_a_to_b_enable_n, byte2_a_to_b_enable_n;
   logic byte1_b_to_a_enable_n, byte2_b_to_a_enable_n;
   logic [17:0] a_in, b_in, a_out, a_oe, b_out, b_oe;
   logic [47:0] o, e;
   stsp_pkg::stsp_obs_s obs_data;
   stsp_pkg::stsp_obs_s got_q[$];
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   int seed = 32'h6af3;
   stsp_tap_core dut_u (.clk, .reset, .tck, .tms, .tdi, .tdo, .tdo_oe,
      .a_in, .b_in, .byte1_a_to_b_enable_n, .byte2_a_to_b_enable_n,
      .byte1_b_to_a_enable_n, .byte2_b_to_a_enable_n, .a_out, .a_oe,
      .b_out, .b_oe, .obs_data, .obs_valid, .obs_ready, .obs_overflow);
   stsp_tap_ctrl ctl_u (.tck, .tms, .tdi, .tdo, .tdo_oe);
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // collects every word taken from the observation stream
   always @(posedge clk)
   begin
      cycles++;
      if (obs_valid === 1'b1 && obs_ready === 1'b1)
         got_q.push_back(obs_data);
      if (cycles == 40000)
      begin
         miscompares++;
         results();
      end
   end
   // ------------------------------------------------------------
   // checking helpers
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] exp,
      input logic [47:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [17:0] shl(input logic [17:0] v);
      return {v[16:0], v[17] ^ v[10]};
   endfunction
   task automatic ir(input logic [7:0] op);
      logic [47:0] so, se;
      logic sx;
      ctl_u.scan(1'b1, {40'h0, op}, 8, so, se, sx);
      chk("ir capture", 48'h81, {40'h0, so[7:0]});
      chk("tdo_oe shift", 48'hff, {40'h0, se[7:0]});
      chk("tdo_oe exit", 48'h0, {47'h0, sx});
   endtask
   // ------------------------------------------------------------
   // one run-test pass: select, seed, run, compare
   // ------------------------------------------------------------
   task automatic run(input logic [2:0] sel, input logic [3:0] en,
      input logic [17:0] p0, input int n, input logic stall);
      logic [47:0] ro, re;
      logic [17:0] s, p, pin, pb;
      logic rx, ok, ba;
      int cnt;
      s = 18'($random(seed));
      pin = 18'($random(seed));
      p = p0;
      pb = '0;
      ba = en[0];
      ok = en[0] != en[2] && en[1] != en[3] && en[0] == en[1];
      // fifo of 8 plus its output register keeps the first 9 words
      cnt = !ok ? 0 : stall ? 9 : n;
      @(posedge clk);
      #1;
      {byte2_b_to_a_enable_n, byte1_b_to_a_enable_n,
         byte2_a_to_b_enable_n, byte1_a_to_b_enable_n} = en;
      // the two sides differ, so the input-side choice shows in the sig
      a_in = pin;
      b_in = ~pin;
      ir(stsp_pkg::OP_SELSCAN);
      ctl_u.scan(1'b0, {45'h0, sel}, 3, ro, re, rx);
      ir(stsp_pkg::OP_SAMPLE);
      ctl_u.scan(1'b0, {en, 8'h00, ba ? {s, p0} : {p0, s}}, 48,
         ro, re, rx);
      ir(stsp_pkg::OP_RUN_TEST_INSTRUCTION);
      @(posedge clk);
      #1;
      obs_ready = !stall;
      got_q.delete();
      ctl_u.idle(1'b0, n);
      repeat (8) @(posedge clk);
      chk("overflow", {47'h0, ok & stall}, {47'h0, obs_overflow});
      chk("out oe", {30'h0, {18{ok}}}, {30'h0, ba ? a_oe : b_oe});
      chk("in oe", 48'h0, {30'h0, ba ? b_oe : a_oe});
      #1;
      obs_ready = 1'b1;
      repeat (30) @(posedge clk);
      chk("words", 48'(cnt), 48'(got_q.size()));
      for (int k = 0; k < n; k++)
      begin
         s = shl(s) ^ (ba ? ~pin : pin);
         p = sel == stsp_pkg::SEL_CMP_CNT ? p + stsp_pkg::CNT_STEP : shl(p);
         if (k == n - 1)
            pb = p;
         if (k < cnt && k < got_q.size())
         begin
            chk("sig", {30'h0, s}, {30'h0, got_q[k].sig});
            chk("pat", {30'h0, p}, {30'h0, got_q[k].pat});
         end
      end
      // pins carry the last pattern from the final fall in run-test
      if (ok)
         chk("pins", {30'h0, pb}, {30'h0, ba ? a_out : b_out});
      ctl_u.idle(1'b1, 5);
      ctl_u.idle(1'b0, 1);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      obs_ready = 1'b1;
      a_in = '0;
      b_in = '0;
      {byte2_b_to_a_enable_n, byte1_b_to_a_enable_n,
         byte2_a_to_b_enable_n, byte1_a_to_b_enable_n} = 4'hc;
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      repeat (4) @(posedge clk);
      ctl_u.idle(1'b0, 1);
      ir(stsp_pkg::OP_BYPASS);
      ctl_u.scan(1'b0, 48'h3, 2, o, e, x);
      chk("bypass", 48'h2, {46'h0, o[1:0]});
      run(stsp_pkg::SEL_CMP_RND, 4'hc, 18'h2d5a7, 6, 1'b0);
      run(stsp_pkg::SEL_CMP_CNT, 4'hc, 18'h3fffe, 12, 1'b1);
      run(stsp_pkg::SEL_CMP_RND, 4'h3, 18'h00000, 5, 1'b0);
      run(stsp_pkg::SEL_CMP_CNT, 4'h3, 18'h00001, 6, 1'b0);
      run(stsp_pkg::SEL_CMP_RND, 4'h8, 18'h00001, 4, 1'b0);
      results();
   end
endmodule // test_scan_tap_signature_pattern_test
